// *** rwsc_map.vh ***
/*
  Constants for the reset, wake and strap controller: register offsets,
  field positions, reset values and timing counts.
  Assumes a 50 MHz core clock and a 32-bit classic Wishbone register bus.
*/
// Behaviour
// - external reset low returns all logic and registers to reset state (crossover and speed strap registers keep following their pins)
// - undriven reset pin reads high; internal power-on reset initialises block
// - host writes ignored after power-up, reset or sleep until one read
// - when enabled, wake event asserts the wake indicator output
// - software picks wake indicator polarity and push-pull or open-drain drive
// - wake event and indicator alone never end reduced-power state
// - any host write cycle ends power-saving mode, whatever data written
// - crossover strap high enables auto crossover; low or open disables it
// - default-speed strap latched when reset released, held as link default
// - strap 0 gives 10M half no autoneg; 1 gives 100M half autoneg
// - reference clock 25 MHz from crystal pair or single-ended oscillator
`ifndef RWSC_MAP_VH
`define RWSC_MAP_VH

// ==========================================================
// register offsets (byte addresses)
`define RWSC_ADR_CTRL 8'h00
`define RWSC_ADR_STATUS 8'h04
`define RWSC_ADR_INT_STAT 8'h08
`define RWSC_ADR_INT_MASK 8'h0C
`define RWSC_ADR_BYTE_TEST 8'h10

// ==========================================================
// control fields
`define RWSC_CTRL_WAKE_EN 0
`define RWSC_CTRL_WAKE_POL 1
`define RWSC_CTRL_WAKE_OD 2
`define RWSC_CTRL_SLEEP 3
`define RWSC_CTRL_WAKE_CLR 4
`define RWSC_CTRL_RST 3'h0

// ==========================================================
// status fields
`define RWSC_ST_SLEEP 0
`define RWSC_ST_READ_DONE 1
`define RWSC_ST_WAKE 2
`define RWSC_ST_SPEED100 3
`define RWSC_ST_AUTONEG 4
`define RWSC_ST_FULL_DUPLEX 5
`define RWSC_ST_XOVER 6

// ==========================================================
// interrupt fields
`define RWSC_IRQ_WAKE 0
`define RWSC_IRQ_RESUME 1
`define RWSC_IRQ_WR_DROP 2
`define RWSC_INT_RST 3'h0

// ==========================================================
// pin synchroniser order and idle values
`define RWSC_PIN_EXT_RST 0
`define RWSC_PIN_CS 1
`define RWSC_PIN_WR 2
`define RWSC_PIN_XOVER 3
`define RWSC_PIN_SPEED 4
`define RWSC_PIN_RST 5'h17

// arbitrary pattern for the byte-order test register
`define RWSC_BYTE_TEST_VAL 32'h0A1B_2C3D

// ==========================================================
// timing
`define RWSC_REF_CLK_HZ 25000000
`define RWSC_CLK_PERIOD_NS 20
`define RWSC_POR_TIME_NS 10000
`define RWSC_POR_CYCLES ((`RWSC_POR_TIME_NS + `RWSC_CLK_PERIOD_NS - 1) / `RWSC_CLK_PERIOD_NS)

`endif

// *** rwsc_sync2.v ***
/*
  Two-flip-flop synchroniser for a vector of independent pin levels.
  Assumes each bit is a slow level; no bit relation is kept across bits.
*/
`timescale 1ns/100ps
`include "rwsc_map.vh"

module rwsc_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire core_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] pinSync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
    end
  end

  assign pinSync = sync_q;

endmodule

// *** rwsc_por.v ***
/*
  Internal power-on reset: holds busy for a fixed time after reset_n rises.
  Assumes reset_n comes from the supply monitor, asynchronous, active low.
*/
`timescale 1ns/100ps
`include "rwsc_map.vh"

module rwsc_por (
  input wire core_clk,
  input wire reset_n,
  output wire porBusy
);

  localparam integer POR_CYCLES = `RWSC_POR_CYCLES;
  localparam [9:0] POR_LAST = POR_CYCLES[9:0];

  reg [9:0] count_q;
  reg busy_q;

  // counts out the power-on time, independent of the reset pin
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 10'h000;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (count_q == POR_LAST - 10'h001) begin
        busy_q <= 1'b0;
      end
      count_q <= count_q + 10'h001;
    end
  end

  assign porBusy = busy_q;

endmodule

// *** rwsc_top.v ***
/*
  Reset, wake and strap controller with a classic Wishbone register slave.
  Assumes core_clk at 50 MHz, straps and host strobes asynchronous pins,
  and wakeEventIn from logic on core_clk.
*/
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "rwsc_map.vh"

module rwsc_top #(
  parameter [31:0] BYTE_TEST_VAL = `RWSC_BYTE_TEST_VAL
) (
  input wire core_clk,
  input wire reset_n,
  input wire ext_reset_pin_n,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire crossover_auto_strap,
  input wire speedStrapIn,
  input wire wakeEventIn,
  input wire ref_osc_in,
  output wire ref_osc_out,
  output wire wake_indicator_out,
  output wire wake_indicator_oe,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire irqOut,
  output wire crossoverEnable,
  output wire linkSpeed100,
  output wire linkFullDuplex,
  output wire autoNegEnable,
  output wire powerSave,
  output wire coreInReset
);

  // ==========================================================
  // reference oscillator
  // crystal amplifier: the output pin is left open with a single-ended source
  assign ref_osc_out = ~ref_osc_in;

  // ==========================================================
  // pin synchronisers
  wire [4:0] pinRaw;
  wire [4:0] pinSync;
  wire extRstS;
  wire csS;
  wire wrS;
  wire xoverS;
  wire speedS;

  assign pinRaw[`RWSC_PIN_EXT_RST] = ext_reset_pin_n;
  assign pinRaw[`RWSC_PIN_CS] = chip_select_n;
  assign pinRaw[`RWSC_PIN_WR] = write_strobe_n;
  assign pinRaw[`RWSC_PIN_XOVER] = crossover_auto_strap;
  assign pinRaw[`RWSC_PIN_SPEED] = speedStrapIn;

  // external reset, host write strobes and straps cross into core_clk first
  rwsc_sync2 #(
    .WIDTH(5),
    .RST_VAL(`RWSC_PIN_RST)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pinIn(pinRaw),
    .pinSync(pinSync)
  );

  assign extRstS = pinSync[`RWSC_PIN_EXT_RST];
  assign csS = pinSync[`RWSC_PIN_CS];
  assign wrS = pinSync[`RWSC_PIN_WR];
  assign xoverS = pinSync[`RWSC_PIN_XOVER];
  assign speedS = pinSync[`RWSC_PIN_SPEED];

  // ==========================================================
  // block reset
  wire porBusy;
  wire blockRst;

  rwsc_por u_por (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .porBusy(porBusy)
  );

  // pin low or power-on still counting holds everything but the strap registers in reset
  assign blockRst = ~extRstS | porBusy;
  assign coreInReset = blockRst;

  // ==========================================================
  // bus decode
  reg ack_q;
  reg [31:0] rdat_q;
  reg readDone_q;
  reg sleep_q;
  reg hostWr_q;
  wire busReq;
  wire busRd;
  wire busWr;
  wire hostWrLvl;
  wire hostWrPulse;
  wire resumeNow;
  wire wrAllowed;
  wire wrDropped;
  wire hitCtrl;
  wire hitStatus;
  wire hitIntStat;
  wire hitIntMask;
  wire hitByteTest;

  assign busReq = wb_cyc_i & wb_stb_i & ~ack_q;
  assign busRd = busReq & ~wb_we_i;
  assign busWr = busReq & wb_we_i;

  assign hitCtrl = (wb_adr_i == `RWSC_ADR_CTRL);
  assign hitStatus = (wb_adr_i == `RWSC_ADR_STATUS);
  assign hitIntStat = (wb_adr_i == `RWSC_ADR_INT_STAT);
  assign hitIntMask = (wb_adr_i == `RWSC_ADR_INT_MASK);
  assign hitByteTest = (wb_adr_i == `RWSC_ADR_BYTE_TEST);

  // ==========================================================
  // host write detect and power-save exit
  assign hostWrLvl = ~csS & ~wrS;
  assign hostWrPulse = hostWrLvl & ~hostWr_q;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hostWr_q <= 1'b0;
    end else if (blockRst) begin
      hostWr_q <= 1'b0;
    end else begin
      hostWr_q <= hostWrLvl;
    end
  end

  // any write cycle wakes, whatever address or data
  assign resumeNow = sleep_q & (busWr | hostWrPulse);

  // writes count only once a read has been done since reset or sleep
  assign wrAllowed = busWr & ~sleep_q & readDone_q;
  assign wrDropped = busWr & ~sleep_q & ~readDone_q;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      readDone_q <= 1'b0;
    end else if (blockRst) begin
      readDone_q <= 1'b0;
    end else if (busRd) begin
      readDone_q <= 1'b1;
    end else if (resumeNow) begin
      readDone_q <= 1'b0;
    end
  end

  // ==========================================================
  // control register
  reg [2:0] ctrl_q;
  wire wakeEn;
  wire wakePol;
  wire wakeOd;
  wire ctrlWr;
  wire wakeClr;
  wire sleepReq;

  assign ctrlWr = wrAllowed & hitCtrl & wb_sel_i[0];
  assign wakeClr = ctrlWr & wb_dat_i[`RWSC_CTRL_WAKE_CLR];
  assign sleepReq = ctrlWr & wb_dat_i[`RWSC_CTRL_SLEEP];
  assign wakeEn = ctrl_q[`RWSC_CTRL_WAKE_EN];
  assign wakePol = ctrl_q[`RWSC_CTRL_WAKE_POL];
  assign wakeOd = ctrl_q[`RWSC_CTRL_WAKE_OD];

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `RWSC_CTRL_RST;
    end else if (blockRst) begin
      ctrl_q <= `RWSC_CTRL_RST;
    end else if (ctrlWr) begin
      ctrl_q <= wb_dat_i[2:0];
    end
  end

  // only a host write or a block reset ends sleep; wake events never touch it
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_q <= 1'b0;
    end else if (blockRst) begin
      sleep_q <= 1'b0;
    end else if (resumeNow) begin
      sleep_q <= 1'b0;
    end else if (sleepReq) begin
      sleep_q <= 1'b1;
    end
  end

  assign powerSave = sleep_q;

  // ==========================================================
  // wake indicator
  reg wake_q;
  reg wakeOut_q;
  reg wakeOe_q;
  wire wakeSet;
  wire wakeLevel;

  assign wakeSet = wakeEn & wakeEventIn & ~wake_q;

  // set wins over a clear in the same cycle
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_q <= 1'b0;
    end else if (blockRst) begin
      wake_q <= 1'b0;
    end else if (wakeEn & wakeEventIn) begin
      wake_q <= 1'b1;
    end else if (wakeClr) begin
      wake_q <= 1'b0;
    end
  end

  // polarity selects the asserted level; open-drain only pulls low
  assign wakeLevel = wake_q ? wakePol : ~wakePol;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeOut_q <= 1'b1;
      wakeOe_q <= 1'b1;
    end else if (blockRst) begin
      wakeOut_q <= 1'b1;
      wakeOe_q <= 1'b1;
    end else if (wakeOd) begin
      wakeOut_q <= 1'b0;
      wakeOe_q <= ~wakeLevel;
    end else begin
      wakeOut_q <= wakeLevel;
      wakeOe_q <= 1'b1;
    end
  end

  assign wake_indicator_out = wakeOut_q;
  assign wake_indicator_oe = wakeOe_q;

  // ==========================================================
  // straps
  reg speed_q;
  reg xover_q;

  // tracks the pin during reset, frozen from release on
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_q <= 1'b1;
    end else if (blockRst) begin
      speed_q <= speedS;
    end
  end

  // pulled-down strap: low or open disables crossover
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      xover_q <= 1'b0;
    end else begin
      xover_q <= xoverS;
    end
  end

  assign crossoverEnable = xover_q;
  // 0: 10M half, no autoneg; 1: 100M half, autoneg
  assign linkSpeed100 = speed_q;
  assign autoNegEnable = speed_q;
  assign linkFullDuplex = 1'b0;

  // ==========================================================
  // interrupts
  reg [2:0] intStat_q;
  reg [2:0] intMask_q;
  reg irq_q;
  wire [2:0] intEvents;
  wire intRdClr;

  assign intEvents[`RWSC_IRQ_WAKE] = wakeSet;
  assign intEvents[`RWSC_IRQ_RESUME] = resumeNow;
  assign intEvents[`RWSC_IRQ_WR_DROP] = wrDropped;
  assign intRdClr = busRd & hitIntStat;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intStat_q <= `RWSC_INT_RST;
    end else if (blockRst) begin
      intStat_q <= `RWSC_INT_RST;
    end else if (intRdClr) begin
      intStat_q <= intEvents;
    end else begin
      intStat_q <= intStat_q | intEvents;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intMask_q <= `RWSC_INT_RST;
    end else if (blockRst) begin
      intMask_q <= `RWSC_INT_RST;
    end else if (wrAllowed & hitIntMask & wb_sel_i[0]) begin
      intMask_q <= wb_dat_i[2:0];
    end
  end

  // irq drops with the rest of the block, not one cycle later
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else if (blockRst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(intStat_q & intMask_q);
    end
  end

  assign irqOut = irq_q;

  // ==========================================================
  // read data and acknowledge
  reg [31:0] rdMux;

  always @* begin
    rdMux = 32'h0000_0000;
    if (hitCtrl) begin
      rdMux[2:0] = ctrl_q;
    end else if (hitStatus) begin
      rdMux[`RWSC_ST_SLEEP] = sleep_q;
      rdMux[`RWSC_ST_READ_DONE] = readDone_q;
      rdMux[`RWSC_ST_WAKE] = wake_q;
      rdMux[`RWSC_ST_SPEED100] = speed_q;
      rdMux[`RWSC_ST_AUTONEG] = speed_q;
      rdMux[`RWSC_ST_FULL_DUPLEX] = 1'b0;
      rdMux[`RWSC_ST_XOVER] = xover_q;
    end else if (hitIntStat) begin
      rdMux[2:0] = intStat_q;
    end else if (hitIntMask) begin
      rdMux[2:0] = intMask_q;
    end else if (hitByteTest) begin
      rdMux = BYTE_TEST_VAL;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (blockRst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= busReq;
      if (busRd) begin
        rdat_q <= rdMux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule

// *** rwsc_top_assertions.sv ***
/* Port checker for rwsc_top, bound into every instance.
   Assumes one core_clk domain and asynchronous active-low reset_n. */
`timescale 1ns/100ps
module rwsc_top_checker (
  input wire core_clk,
  input wire reset_n,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire crossover_auto_strap,
  input wire ref_osc_in,
  input wire ref_osc_out,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire wb_ack_o,
  input wire irqOut,
  input wire crossoverEnable,
  input wire linkSpeed100,
  input wire linkFullDuplex,
  input wire autoNegEnable,
  input wire powerSave,
  input wire coreInReset
);
  // ==========================================================
  // recent host pin write strobes
  wire pinWr = !chip_select_n && !write_strobe_n;
  reg [4:0] pinWr_q;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) pinWr_q <= 5'h0;
    else pinWr_q <= {pinWr_q[3:0], pinWr};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // assertions
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !coreInReset |=> wb_ack_o)
    else $error("no ack");
  a_osc_invert: assert property (ref_osc_out == !ref_osc_in) else $error("osc out");
  a_xover_follow: assert property ((!coreInReset && $stable(crossover_auto_strap))[*4]
    |-> crossoverEnable == crossover_auto_strap) else $error("crossover");
  a_speed_hold: assert property ((!coreInReset)[*3] |-> $stable(linkSpeed100))
    else $error("speed moved");
  a_link_defaults: assert property (autoNegEnable == linkSpeed100 && !linkFullDuplex)
    else $error("link defaults");
  a_sleep_exit: assert property ($fell(powerSave) && !coreInReset && !$past(coreInReset)
    |-> (wb_ack_o && wb_we_i) || (|pinWr_q)) else $error("wake without write");
  a_pin_wake: assert property ($rose(pinWr) && powerSave && !coreInReset |-> ##[1:5] !powerSave)
    else $error("pin write no wake");
  c_wake: cover property ($fell(powerSave));
  c_write: cover property (wb_ack_o && wb_we_i);
  c_irq: cover property ($rose(irqOut));
endmodule
bind rwsc_top rwsc_top_checker i_chk (.core_clk, .reset_n, .chip_select_n, .write_strobe_n,
  .crossover_auto_strap, .ref_osc_in, .ref_osc_out, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .irqOut, .crossoverEnable, .linkSpeed100, .linkFullDuplex, .autoNegEnable, .powerSave,
  .coreInReset);

// *** rwsc_host_model.sv ***
/* Host model: classic Wishbone master and host write pins.
   Assumes calls start just after a rising edge; expected read data queued. */
`timescale 1ns/100ps
module rwsc_host_model (
  input wire core_clk,
  input wire wb_ack_o,
  output reg wb_cyc_i,
  output reg wb_stb_i,
  output reg wb_we_i,
  output reg [7:0] wb_adr_i,
  output reg [3:0] wb_sel_i,
  output reg [31:0] wb_dat_i,
  output reg chip_select_n,
  output reg write_strobe_n
);
  logic [31:0] expQ[$];
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
  end
  // for reads dat is the expected word
  task xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    if (!we) expQ.push_back(dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= we ? dat : ~wb_dat_i;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 50) begin
      rwsc_top_tb_top.numErrors++;
      rwsc_top_tb_top.stopTest;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~adr;
    wb_dat_i <= ~wb_dat_i;
    @(posedge core_clk);
  endtask
  task pinWrite;
    chip_select_n <= 1'b0;
    write_strobe_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chip_select_n <= 1'b1;
    write_strobe_n <= 1'b1;
    @(posedge core_clk);
  endtask
endmodule

// *** rwsc_top_tb_top.sv ***
/* Self-checking bench for rwsc_top with a host model.
   Assumes the register map of rwsc_map.vh and a 50 MHz core_clk. */
`timescale 1ns/100ps
`include "rwsc_map.vh"
module rwsc_top_tb_top;
  reg core_clk, reset_n, ext_reset_pin_n, crossover_auto_strap, speedStrapIn, wakeEventIn;
  reg ref_osc_in;
  wire chip_select_n, write_strobe_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irqOut;
  wire ref_osc_out, wake_indicator_out, wake_indicator_oe, crossoverEnable, linkSpeed100;
  wire linkFullDuplex, autoNegEnable, powerSave, coreInReset;
  wire [7:0] wb_adr_i;
  wire [3:0] wb_sel_i;
  wire [31:0] wb_dat_i, wb_dat_o;
  int numErrors = 0;
  int checksDone = 0;
  reg [7:0] rnd;
  rwsc_top i_dut (.core_clk, .reset_n, .ext_reset_pin_n, .chip_select_n, .write_strobe_n,
    .crossover_auto_strap, .speedStrapIn, .wakeEventIn, .ref_osc_in, .ref_osc_out,
    .wake_indicator_out, .wake_indicator_oe, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irqOut, .crossoverEnable, .linkSpeed100,
    .linkFullDuplex, .autoNegEnable, .powerSave, .coreInReset);
  rwsc_host_model i_host (.core_clk, .wb_ack_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .chip_select_n, .write_strobe_n);
  always #10 core_clk = ~core_clk;
  always #20 ref_osc_in = ~ref_osc_in;
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stopTest;
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task waitReady;
    int n;
    n = 0;
    while (coreInReset !== 1'b0 && n < 700) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 700) begin
      numErrors++;
      stopTest;
    end
  endtask
  task wakePulse;
    wakeEventIn <= 1'b1;
    @(posedge core_clk);
    wakeEventIn <= 1'b0;
    tick(3);
  endtask
  // read data monitor takes the oldest expectation
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check("readData", wb_dat_o, i_host.expQ.size() ? i_host.expQ.pop_front() : 32'hx);
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    numErrors++;
    stopTest;
  end
  initial begin
    core_clk = 0;
    ref_osc_in = 0;
    reset_n = 0;
    ext_reset_pin_n = 1;
    wakeEventIn = 0;
    rnd = lfsr(8'h1C);
    crossover_auto_strap = rnd[0];
    speedStrapIn = rnd[1];
    tick(20);
    reset_n <= 1'b1;
    waitReady;
    check("speed", linkSpeed100, speedStrapIn);
    check("autoNeg", autoNegEnable, speedStrapIn);
    check("duplex", linkFullDuplex, 1'b0);
    check("xover", crossoverEnable, crossover_auto_strap);
    check("wakeIdle", {wake_indicator_out, wake_indicator_oe}, 2'h3);
    crossover_auto_strap <= ~crossover_auto_strap;
    speedStrapIn <= ~speedStrapIn;
    tick(5);
    check("xover", crossoverEnable, crossover_auto_strap);
    check("speedHeld", linkSpeed100, !speedStrapIn);
    $display("straps done");
    i_host.xfer(1, `RWSC_ADR_CTRL, 32'h1);
    i_host.xfer(0, `RWSC_ADR_INT_STAT, 32'h4);
    i_host.xfer(0, `RWSC_ADR_CTRL, 32'h0);
    i_host.xfer(0, 8'h20, 32'h0);
    i_host.xfer(0, `RWSC_ADR_BYTE_TEST, `RWSC_BYTE_TEST_VAL);
    i_host.xfer(1, `RWSC_ADR_INT_MASK, 32'h7);
    i_host.xfer(0, `RWSC_ADR_INT_MASK, 32'h7);
    $display("first read done");
    i_host.xfer(1, `RWSC_ADR_CTRL, 32'h3);
    tick(2);
    check("wakeHigh", {wake_indicator_out, wake_indicator_oe}, 2'h1);
    wakePulse;
    check("wakeHigh", wake_indicator_out, 1'b1);
    check("irq", irqOut, 1'b1);
    i_host.xfer(0, `RWSC_ADR_INT_STAT, 32'h1);
    tick(2);
    check("irq", irqOut, 1'b0);
    i_host.xfer(1, `RWSC_ADR_CTRL, 32'h15);
    tick(2);
    check("odIdle", wake_indicator_oe, 1'b0);
    wakePulse;
    check("odActive", {wake_indicator_out, wake_indicator_oe}, 2'h1);
    $display("wake done");
    i_host.xfer(1, `RWSC_ADR_CTRL, 32'h19);
    tick(2);
    wakePulse;
    tick(3);
    check("sleep", powerSave, 1'b1);
    check("wakeLow", wake_indicator_out, 1'b0);
    rnd = lfsr(rnd);
    i_host.xfer(1, `RWSC_ADR_BYTE_TEST, {4{rnd}});
    check("awake", powerSave, 1'b0);
    i_host.xfer(1, `RWSC_ADR_INT_MASK, 32'h0);
    i_host.xfer(0, `RWSC_ADR_INT_MASK, 32'h7);
    i_host.xfer(1, `RWSC_ADR_CTRL, 32'h8);
    tick(2);
    i_host.pinWrite;
    tick(4);
    check("pinAwake", powerSave, 1'b0);
    $display("sleep done");
    speedStrapIn <= ~speedStrapIn;
    ext_reset_pin_n <= 1'b0;
    tick(4);
    check("inReset", coreInReset, 1'b1);
    ext_reset_pin_n <= 1'b1;
    waitReady;
    check("speed", linkSpeed100, speedStrapIn);
    i_host.xfer(0, `RWSC_ADR_INT_MASK, 32'h0);
    i_host.xfer(0, `RWSC_ADR_CTRL, 32'h0);
    i_host.xfer(0, `RWSC_ADR_STATUS, {25'h0, crossover_auto_strap, 1'b0, speedStrapIn,
      speedStrapIn, 3'b010});
    $display("reset done");
    stopTest;
  end
endmodule
